// ---- vmic_ctl.sv ----
// Operation
// - Channel one: pick level, enable detect circuit, then wait settle time.
// - After settling, set comparator path bit, then pick interrupt type.
// - Filter: pick sampling divider then clear bypass; no filter: set bypass.
// - Set edge mode and condition bit after filter configuration.
// - Clear change flag after timing selection, before enabling interrupt.
// - With filter, start low-speed oscillator by writing 0 to its stop bit.
// - With filter, wait two sampling clocks before enabling; none otherwise.
// - Last step: set the channel interrupt enable bit.
// - With enable at 0, comparator/type and divider/bypass may share writes.
// - After enabling, read the flag; if 1, handle low voltage in software.
// - Channel two follows the same order without level selection.
// - Channel one stop-mode wake needs bypass set; device delivers unfiltered.
// - Channel two stop-mode wake needs bypass set; device delivers unfiltered.
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
module vmic_ctl
    import vmic_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = SETTLE_CYC, // Detect circuit settle wait
    parameter int unsigned LOCO_CYCLES   = LOCO_CYC    // Clocks per oscillator period
)(
    input  wire logic        clock_in,      // 40 MHz clock
    input  wire logic        rst_n_in,      // Async reset, active low
    input  wire logic        psel_in,       // APB select
    input  wire logic        penable_in,    // APB enable
    input  wire logic        pwrite_in,     // APB direction
    input  wire logic [7:0]  paddr_in,      // APB byte address
    input  wire logic [31:0] pwdata_in,     // APB write data
    output logic [31:0]      prdata_out,    // APB read data
    output logic             pready_out,    // APB ready
    output logic             pslverr_out,   // APB error on unmapped address
    output logic [7:0]       dev_addr_out,  // Device register address
    output logic [7:0]       dev_wdata_out, // Device write data
    output logic             dev_wr_out,    // Device write strobe
    output logic             dev_rd_out,    // Device read strobe
    input  wire logic [7:0]  dev_rdata_in,  // Device read data
    input  wire logic [1:0]  dev_irq_in,    // Device monitor interrupt requests
    output logic             irq_out        // Level interrupt
);
    function automatic logic [7:0] vmic_bit(input int unsigned pos);
        return 8'h01 << pos;
    endfunction : vmic_bit

    function automatic logic [7:0] vmic_mon_addr(input logic ch);
        return ch ? DEV_MON2_ADDR : DEV_MON1_ADDR;
    endfunction : vmic_mon_addr

    vmic_acc_if  acc ();
    vmic_state_t state_q;
    logic        ch_q;
    logic [9:0]  cfg1_q;
    logic [9:0]  cfg2_q;
    logic [9:0]  cfg;
    logic [5:0]  istat_q;
    logic [5:0]  istat_d;
    logic [5:0]  imask_q;
    logic [5:0]  events;
    logic [1:0]  irq_prev_q;
    logic [1:0]  enabled_q;
    logic        clr_seen_q;
    logic        tmr_load_q;
    logic        tmr_zero;
    logic [15:0] tmr_count_q;
    logic        access;
    logic        wr_en;
    logic        mapped;
    logic [31:0] rd_mux;
    logic        cmd_start;
    logic        cmd_off;
    logic        setup_done;
    logic        pend_seen;

    vmic_dev_port u_port (
        .clock_in      (clock_in),
        .rst_n_in      (rst_n_in),
        .acc           (acc.port),
        .dev_addr_out  (dev_addr_out),
        .dev_wdata_out (dev_wdata_out),
        .dev_wr_out    (dev_wr_out),
        .dev_rd_out    (dev_rd_out),
        .dev_rdata_in  (dev_rdata_in)
    );

    vmic_timer u_timer (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .load_in  (tmr_load_q),
        .count_in (tmr_count_q),
        .zero_out (tmr_zero)
    );

    // APB slave: pready comes one access cycle late so every output is a flop
    assign access = psel_in && penable_in;
    assign wr_en  = access && pready_out && pwrite_in;
    assign cfg    = ch_q ? cfg2_q : cfg1_q;

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr_in)
            REG_CTRL:   rd_mux = 32'h0000_0000;
            REG_CFG1:   rd_mux = {22'h000000, cfg1_q};
            REG_CFG2:   rd_mux = {22'h000000, cfg2_q};
            REG_STATUS: rd_mux = {24'h000000, enabled_q, ch_q, state_q, (state_q != ST_IDLE)};
            REG_ISTAT:  rd_mux = {26'h0000000, istat_q};
            REG_IMASK:  rd_mux = {26'h0000000, imask_q};
            default:    mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_out  <= 1'b0;
            prdata_out  <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end else begin
            pready_out  <= access && !pready_out;
            prdata_out  <= (access && !pready_out && !pwrite_in) ? rd_mux : 32'h0000_0000;
            pslverr_out <= access && !pready_out && !mapped;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg1_q  <= CFG_RESET;
            cfg2_q  <= CFG_RESET;
            imask_q <= 6'h00;
        end else if (wr_en) begin
            if (paddr_in == REG_CFG1) cfg1_q <= pwdata_in[9:0];
            if (paddr_in == REG_CFG2) cfg2_q <= pwdata_in[9:0];
            if (paddr_in == REG_IMASK) imask_q <= pwdata_in[5:0];
        end
    end

    // Commands arriving while a sequence runs are dropped; software polls busy
    assign cmd_start = wr_en && (paddr_in == REG_CTRL) && pwdata_in[CTRL_START] && (state_q == ST_IDLE);
    assign cmd_off   = wr_en && (paddr_in == REG_CTRL) && pwdata_in[CTRL_OFF] && !pwdata_in[CTRL_START]
                       && (state_q == ST_IDLE);

    // One device access per state, none in idle, settle wait and filter wait
    always_comb begin
        acc.req      = 1'b1;
        acc.rd_only  = 1'b0;
        acc.addr     = vmic_mon_addr(ch_q);
        acc.set_mask = 8'h00;
        acc.clr_mask = 8'h00;
        case (state_q)
            ST_LEVEL: begin
                acc.addr     = DEV_LEVEL1_ADDR;
                acc.clr_mask = LEVEL_MASK;
                acc.set_mask = {4'h0, cfg1_q[3:0]};
            end
            ST_CIRC: begin
                acc.addr     = DEV_CIRC_ADDR;
                acc.set_mask = vmic_bit(ch_q ? CIRC2_BIT : CIRC1_BIT);
            end
            ST_CMP: begin
                acc.addr     = DEV_CMP_ADDR;
                acc.clr_mask = vmic_bit(ch_q ? MON2_IRQ_TYPE_SEL_BIT : MON1_IRQ_TYPE_SEL_BIT);
                acc.set_mask = vmic_bit(COMPARATOR_PATH_SEL_BIT) | (cfg[CFG_TYPE] ? acc.clr_mask : 8'h00);
            end
            ST_FILT: begin
                acc.clr_mask = vmic_bit(MON_ENABLE_BIT) | vmic_bit(MON_BYPASS_BIT) | MON_DIV_MASK;
                acc.set_mask = cfg[CFG_BYPASS] ? vmic_bit(MON_BYPASS_BIT)
                             : ({6'h00, cfg[CFG_DIV_POS+1:CFG_DIV_POS]} << MON_DIV_POS);
            end
            ST_EDGE: begin
                acc.addr     = DEV_EDGE_ADDR;
                acc.clr_mask = vmic_bit(ch_q ? EDGE2_BIT : EDGE1_BIT);
                acc.set_mask = cfg[CFG_EDGE] ? acc.clr_mask : 8'h00;
            end
            ST_COND: begin
                acc.clr_mask = vmic_bit(MON_COND_BIT);
                acc.set_mask = cfg[CFG_COND] ? acc.clr_mask : 8'h00;
            end
            ST_CLRFLAG: acc.clr_mask = vmic_bit(MON_FLAG_BIT);
            ST_OSC: begin
                acc.addr     = DEV_CLK1_ADDR;
                acc.clr_mask = vmic_bit(OSC_STOP_BIT);
            end
            ST_ENABLE: acc.set_mask = vmic_bit(MON_ENABLE_BIT);
            ST_CHECK:  acc.rd_only  = 1'b1;
            ST_OFF:    acc.clr_mask = vmic_bit(MON_ENABLE_BIT);
            default:   acc.req      = 1'b0;
        endcase
    end

    // Setup sequencer
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q     <= ST_IDLE;
            ch_q        <= 1'b0;
            tmr_load_q  <= 1'b0;
            tmr_count_q <= 16'h0000;
        end else begin
            tmr_load_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (cmd_start) begin
                        ch_q    <= pwdata_in[CTRL_CHAN];
                        state_q <= pwdata_in[CTRL_CHAN] ? ST_CIRC : ST_LEVEL;
                    end else if (cmd_off) begin
                        ch_q    <= pwdata_in[CTRL_CHAN];
                        state_q <= ST_OFF;
                    end
                end
                ST_LEVEL:   if (acc.done) state_q <= ST_CIRC;
                ST_CIRC: begin
                    if (acc.done) begin
                        tmr_load_q  <= 1'b1;
                        tmr_count_q <= 16'(SETTLE_CYCLES);
                        state_q     <= ST_SETTLE;
                    end
                end
                ST_SETTLE:  if (!tmr_load_q && tmr_zero) state_q <= ST_CMP;
                ST_CMP:     if (acc.done) state_q <= ST_FILT;
                ST_FILT:    if (acc.done) state_q <= ST_EDGE;
                ST_EDGE:    if (acc.done) state_q <= ST_COND;
                ST_COND:    if (acc.done) state_q <= ST_CLRFLAG;
                ST_CLRFLAG: if (acc.done) state_q <= cfg[CFG_BYPASS] ? ST_ENABLE : ST_OSC;
                ST_OSC: begin
                    if (acc.done) begin
                        tmr_load_q  <= 1'b1;
                        // Two periods of the divided oscillator clock
                        tmr_count_q <= 16'(FWAIT_SAMPLES * LOCO_CYCLES * (32'd1 << cfg[CFG_DIV_POS+1:CFG_DIV_POS]));
                        state_q     <= ST_FWAIT;
                    end
                end
                ST_FWAIT:   if (!tmr_load_q && tmr_zero) state_q <= ST_ENABLE;
                ST_ENABLE:  if (acc.done) state_q <= ST_CHECK;
                ST_CHECK:   if (acc.done) state_q <= ST_IDLE;
                ST_OFF:     if (acc.done) state_q <= ST_IDLE;
                default:    state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clr_seen_q <= 1'b0;
            enabled_q  <= 2'b00;
        end else begin
            if (cmd_start) clr_seen_q <= 1'b0;
            else if (state_q == ST_CLRFLAG && acc.done) clr_seen_q <= 1'b1;
            if (state_q == ST_ENABLE && acc.done) enabled_q[ch_q] <= 1'b1;
            if (state_q == ST_OFF && acc.done) enabled_q[ch_q] <= 1'b0;
        end
    end

    // Events: setup done, flag found set after enable, device request edge.
    // Detections during setup raise no request, so the flag read is the only trace.
    assign setup_done = (state_q == ST_CHECK) && acc.done;
    assign pend_seen  = setup_done && acc.rdata[MON_FLAG_BIT];
    assign events     = {dev_irq_in & ~irq_prev_q,
                         pend_seen && ch_q, pend_seen && !ch_q, setup_done && ch_q, setup_done && !ch_q};
    // A new event wins over a write-one clear in the same cycle
    assign istat_d    = (istat_q & ~((wr_en && paddr_in == REG_ISTAT) ? pwdata_in[5:0] : 6'h00)) | events;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            istat_q    <= 6'h00;
            irq_prev_q <= 2'b00;
            irq_out    <= 1'b0;
        end else begin
            istat_q    <= istat_d;
            irq_prev_q <= dev_irq_in;
            irq_out    <= |(istat_q & imask_q);
        end
    end

    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    a_settle_hold: assert property ($rose(state_q == ST_SETTLE) |-> (state_q == ST_SETTLE)[*8])
        else $error("settle wait ended too early");

    a_circ_on: assert property ((dev_wr_out && state_q == ST_CIRC)
        |-> (dev_wdata_out & vmic_bit(ch_q ? CIRC2_BIT : CIRC1_BIT)) != 8'h00)
        else $error("detect circuit not switched on");

    a_comp_sel: assert property ((dev_wr_out && state_q == ST_CMP) |-> dev_wdata_out[COMPARATOR_PATH_SEL_BIT])
        else $error("comparator path bit not set");

    a_type_write: assert property ((dev_wr_out && state_q == ST_CMP)
        |-> dev_wdata_out[ch_q ? MON2_IRQ_TYPE_SEL_BIT : MON1_IRQ_TYPE_SEL_BIT] == cfg[CFG_TYPE])
        else $error("interrupt type bit wrong");

    a_bypass_write: assert property ((dev_wr_out && state_q == ST_FILT)
        |-> dev_wdata_out[MON_BYPASS_BIT] == cfg[CFG_BYPASS] && !dev_wdata_out[MON_ENABLE_BIT])
        else $error("bypass or enable bit wrong in filter write");

    a_div_write: assert property ((dev_wr_out && state_q == ST_FILT && !cfg[CFG_BYPASS])
        |-> dev_wdata_out[MON_DIV_POS +: 2] == cfg[CFG_DIV_POS +: 2])
        else $error("sampling divider code wrong");

    a_timing_order: assert property ($rose(state_q == ST_EDGE) |-> $past(state_q) == ST_FILT)
        else $error("timing selection before filter setup");

    a_edge_write: assert property ((dev_wr_out && state_q == ST_EDGE)
        |-> dev_wdata_out[ch_q ? EDGE2_BIT : EDGE1_BIT] == cfg[CFG_EDGE])
        else $error("edge mode bit wrong");

    a_cond_write: assert property ((dev_wr_out && state_q == ST_COND)
        |-> dev_wdata_out[MON_COND_BIT] == cfg[CFG_COND])
        else $error("condition bit wrong");

    a_flag_cleared: assert property ((dev_wr_out && state_q == ST_CLRFLAG) |-> !dev_wdata_out[MON_FLAG_BIT])
        else $error("flag not written as zero");

    a_osc_first: assert property ($rose(state_q == ST_FWAIT) |-> $past(state_q) == ST_OSC)
        else $error("filter wait without oscillator start");

    a_osc_clear: assert property ((dev_wr_out && state_q == ST_OSC) |-> !dev_wdata_out[OSC_STOP_BIT])
        else $error("oscillator stop bit not cleared");

    a_filter_wait: assert property (($rose(state_q == ST_ENABLE) && !cfg[CFG_BYPASS])
        |-> $past(state_q) == ST_FWAIT)
        else $error("enable without filter wait");

    a_enable_last: assert property ((dev_wr_out && state_q == ST_ENABLE)
        |-> clr_seen_q && dev_wdata_out[MON_ENABLE_BIT])
        else $error("enable before flag clear");

    a_check_after: assert property ($rose(state_q == ST_CHECK) |-> $past(state_q) == ST_ENABLE)
        else $error("flag read not after enable");

    a_pending_flag: assert property (pend_seen |=> istat_q[{1'b0, ch_q} + 2'd2]
        ##1 (irq_out || !imask_q[{1'b0, ch_q} + 2'd2]))
        else $error("pending flag not reported");

    a_no_level_ch2: assert property ((state_q == ST_LEVEL) |-> !ch_q)
        else $error("level step on channel two");

    // Request edges from monitor one must land in status one cycle later
    a_event_flag: assert property ((dev_irq_in[0] && !irq_prev_q[0]) |=> istat_q[4])
        else $error("monitor request not recorded");

    a_irq_level: assert property (irq_out == (|$past(istat_q & imask_q)))
        else $error("interrupt output does not follow status");
endmodule : vmic_ctl

// ---- vmic_pkg.sv ----
package vmic_pkg;
    // Device register byte addresses on the device access port
    localparam logic [7:0] DEV_LEVEL1_ADDR  = 8'h36;
    localparam logic [7:0] DEV_CIRC_ADDR    = 8'h34;
    localparam logic [7:0] DEV_CMP_ADDR     = 8'h30;
    localparam logic [7:0] DEV_EDGE_ADDR    = 8'h35;
    localparam logic [7:0] DEV_CLK1_ADDR    = 8'h07;
    localparam logic [7:0] DEV_MON1_ADDR    = 8'h39;
    localparam logic [7:0] DEV_MON2_ADDR    = 8'h3a;
    // Device field positions
    localparam int unsigned CIRC1_BIT       = 6;
    localparam int unsigned CIRC2_BIT       = 7;
    localparam int unsigned COMPARATOR_PATH_SEL_BIT     = 0;
    localparam int unsigned MON1_IRQ_TYPE_SEL_BIT     = 1;
    localparam int unsigned MON2_IRQ_TYPE_SEL_BIT     = 2;
    localparam int unsigned EDGE1_BIT       = 1;
    localparam int unsigned EDGE2_BIT       = 2;
    localparam int unsigned OSC_STOP_BIT    = 4;
    localparam int unsigned MON_ENABLE_BIT  = 0;
    localparam int unsigned MON_BYPASS_BIT  = 1;
    localparam int unsigned MON_FLAG_BIT    = 2;
    localparam int unsigned MON_DIV_POS     = 4;
    localparam int unsigned MON_COND_BIT    = 7;
    localparam logic [7:0]  LEVEL_MASK      = 8'h0f;
    localparam logic [7:0]  MON_DIV_MASK    = 8'h30;
    // APB register offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_CFG1   = 8'h04;
    localparam logic [7:0] REG_CFG2   = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_ISTAT  = 8'h10;
    localparam logic [7:0] REG_IMASK  = 8'h14;
    // CTRL and CFG fields
    localparam int unsigned CTRL_START  = 0;
    localparam int unsigned CTRL_CHAN   = 1;
    localparam int unsigned CTRL_OFF    = 2;
    localparam int unsigned CFG_DIV_POS = 4;
    localparam int unsigned CFG_BYPASS  = 6;
    localparam int unsigned CFG_TYPE    = 7;
    localparam int unsigned CFG_EDGE    = 8;
    localparam int unsigned CFG_COND    = 9;
    localparam logic [9:0]  CFG_RESET   = 10'h040;
    // Timing: settle time and oscillator period in ns, counts rounded up
    localparam int unsigned CLK_NS     = 25;
    localparam int unsigned SETTLE_NS  = 100000;
    localparam int unsigned SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned LOCO_NS    = 8000;
    localparam int unsigned LOCO_CYC   = (LOCO_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned FWAIT_SAMPLES = 2;
    typedef enum logic [3:0] {ST_IDLE, ST_LEVEL, ST_CIRC, ST_SETTLE, ST_CMP, ST_FILT, ST_EDGE, ST_COND,
                              ST_CLRFLAG, ST_OSC, ST_FWAIT, ST_ENABLE, ST_CHECK, ST_OFF} vmic_state_t;
    typedef enum logic [1:0] {PH_IDLE, PH_READ, PH_CAP, PH_WRITE} vmic_phase_t;
endpackage : vmic_pkg

// ---- vmic_acc_if.sv ----
`timescale 1ns/10ps
interface vmic_acc_if;
    logic       req;
    logic       rd_only;
    logic [7:0] addr;
    logic [7:0] set_mask;
    logic [7:0] clr_mask;
    logic       done;
    logic [7:0] rdata;
    modport ctl  (output req, rd_only, addr, set_mask, clr_mask, input done, rdata);
    modport port (input req, rd_only, addr, set_mask, clr_mask, output done, rdata);
endinterface : vmic_acc_if

// ---- vmic_timer.sv ----
`timescale 1ns/10ps
module vmic_timer
    import vmic_pkg::*;
(
    input  wire logic        clock_in,   // 40 MHz clock
    input  wire logic        rst_n_in,   // Async reset
    input  wire logic        load_in,    // Load count
    input  wire logic [15:0] count_in,   // Cycles to wait
    output logic             zero_out    // Count run out
);
    logic [15:0] cnt_q;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= 16'h0000;
        end else if (load_in) begin
            cnt_q <= count_in;
        end else if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
        end
    end

    assign zero_out = (cnt_q == 16'h0000);
endmodule : vmic_timer

// ---- vmic_dev_port.sv ----
`timescale 1ns/10ps
module vmic_dev_port
    import vmic_pkg::*;
(
    input  wire logic        clock_in,      // 40 MHz clock
    input  wire logic        rst_n_in,      // Async reset
    vmic_acc_if.port         acc,           // Access request
    output logic [7:0]       dev_addr_out,  // Device address
    output logic [7:0]       dev_wdata_out, // Device write data
    output logic             dev_wr_out,    // Write strobe
    output logic             dev_rd_out,    // Read strobe
    input  wire logic [7:0]  dev_rdata_in   // Read data, cycle after strobe
);
    vmic_phase_t ph_q;
    logic [7:0]  rdata_q;
    logic        done_q;

    // Every change is read-modify-write so untouched bits keep their value;
    // a read flag of 1 written back leaves the flag alone.
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ph_q          <= PH_IDLE;
            dev_addr_out  <= 8'h00;
            dev_wdata_out <= 8'h00;
            dev_wr_out    <= 1'b0;
            dev_rd_out    <= 1'b0;
            rdata_q       <= 8'h00;
            done_q        <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (ph_q)
                PH_IDLE: begin
                    if (acc.req && !done_q) begin
                        dev_addr_out <= acc.addr;
                        dev_rd_out   <= 1'b1;
                        ph_q         <= PH_READ;
                    end
                end
                PH_READ: begin
                    dev_rd_out <= 1'b0;
                    ph_q       <= PH_CAP;
                end
                PH_CAP: begin
                    rdata_q <= dev_rdata_in;
                    if (acc.rd_only) begin
                        done_q <= 1'b1;
                        ph_q   <= PH_IDLE;
                    end else begin
                        dev_wdata_out <= (dev_rdata_in & ~acc.clr_mask) | acc.set_mask;
                        dev_wr_out    <= 1'b1;
                        ph_q          <= PH_WRITE;
                    end
                end
                PH_WRITE: begin
                    dev_wr_out <= 1'b0;
                    done_q     <= 1'b1;
                    ph_q       <= PH_IDLE;
                end
                default: ph_q <= PH_IDLE;
            endcase
        end
    end

    assign acc.done  = done_q;
    assign acc.rdata = rdata_q;
endmodule : vmic_dev_port

// ---- vmic_dev_model.sv ----
`timescale 1ns/10ps
module vmic_dev_model
    import vmic_pkg::*;
(
    input  wire logic       clock_in,  // Clock
    input  wire logic [7:0] addr_in,   // Register address
    input  wire logic [7:0] wdata_in,  // Write data
    input  wire logic       wr_in,     // Write strobe
    input  wire logic       rd_in,     // Read strobe
    input  wire logic [1:0] low_in,    // Low supply seen
    output logic      [7:0] rdata_out, // Read data
    output logic      [1:0] irq_out    // Monitor requests
);
    logic [7:0] regs [256];
    logic [1:0] low_q = 2'b00;
    logic [7:0] a;
    initial begin
        foreach (regs[i]) regs[i] = 8'h00;
        regs[DEV_MON1_ADDR] = 8'h82;
        regs[DEV_MON2_ADDR] = 8'h82;
        regs[DEV_CLK1_ADDR] = 8'h10;
        rdata_out = 8'h00;
        irq_out = 2'b00;
    end
    // Data valid only in the cycle after the strobe, scrambled otherwise
    always @(posedge clock_in) begin
        rdata_out <= rd_in ? regs[addr_in] : ~rdata_out;
        irq_out <= 2'b00;
        low_q <= low_in;
        if (wr_in) begin
            regs[addr_in] <= wdata_in;
            if (addr_in == DEV_MON1_ADDR || addr_in == DEV_MON2_ADDR)
                regs[addr_in][2] <= wdata_in[2] & regs[addr_in][2];
        end
        for (int c = 0; c < 2; c++) begin
            a = c ? DEV_MON2_ADDR : DEV_MON1_ADDR;
            if (regs[DEV_CIRC_ADDR][6 + c]) begin
                if (!regs[a][0]) begin
                    if (low_in[c]) regs[a][2] <= 1'b1;
                end else if (low_in[c] != low_q[c] && low_in[c] == regs[a][7]) begin
                    regs[a][2] <= 1'b1;
                    irq_out[c] <= 1'b1;
                end
            end
        end
    end
endmodule : vmic_dev_model

// ---- voltage_monitor_interrupt_ctl_tb.sv ----
`timescale 1ns/10ps
module voltage_monitor_interrupt_ctl_tb
    import vmic_pkg::*;
;
    `define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
        $display("[FAIL] %s exp %h got %h", n, e, g); end end
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0, dev_addr, dev_wdata, dev_rdata;
    logic [31:0] pwdata = 0, prdata, r;
    logic pready, pslverr, dev_wr, dev_rd, irq, e;
    logic [1:0] dev_irq, low = 0;
    int miscompares = 0, num_checks = 0;
    typedef struct {logic [7:0] a; logic [31:0] d; logic err;} vmic_row_t;
    vmic_row_t rows [7] = '{'{REG_CTRL, 0, 0}, '{REG_CFG1, 32'h40, 0}, '{REG_CFG2, 32'h40, 0},
        '{REG_STATUS, 0, 0}, '{REG_ISTAT, 0, 0}, '{REG_IMASK, 0, 0}, '{8'h18, 0, 1}};
    vmic_ctl #(.SETTLE_CYCLES(10), .LOCO_CYCLES(2)) dut (.clock_in(clk), .rst_n_in(rst_n),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .dev_addr_out(dev_addr),
        .dev_wdata_out(dev_wdata), .dev_wr_out(dev_wr), .dev_rd_out(dev_rd), .dev_rdata_in(dev_rdata),
        .dev_irq_in(dev_irq), .irq_out(irq));
    vmic_dev_model m (.clock_in(clk), .addr_in(dev_addr), .wdata_in(dev_wdata), .wr_in(dev_wr),
        .rd_in(dev_rd), .low_in(low), .rdata_out(dev_rdata), .irq_out(dev_irq));
    initial forever #12.5 clk = ~clk;
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk) penable <= 1;
        // Only the watchdog ends a wait for ready
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    // Poll busy; a stuck sequence counts as a mismatch
    task automatic wait_idle;
        repeat (200) begin apb(0, REG_STATUS, 0); if (r[0] === 1'b0) return; end
        miscompares++;
        $display("[FAIL] busy exp 0 got 1");
    endtask : wait_idle
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_sim();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1;
        foreach (rows[i]) begin
            apb(0, rows[i].a, 0);
            `CHK("reset read", rows[i].d, r)
            `CHK("slverr", rows[i].err, e)
        end
        $display("test reset values done");
        apb(1, REG_IMASK, 32'h3f);
        apb(1, REG_CFG1, 32'h245);
        apb(1, REG_CTRL, 32'h1);
        repeat (20) @(posedge clk);
        low[0] <= 1;
        wait_idle();
        `CHK("lvl", 8'h05, m.regs[DEV_LEVEL1_ADDR] & LEVEL_MASK)
        `CHK("circ1", 1'b1, m.regs[DEV_CIRC_ADDR][6])
        `CHK("cmp", 1'b1, m.regs[DEV_CMP_ADDR][0])
        `CHK("mon1", 8'h87, m.regs[DEV_MON1_ADDR])
        apb(0, REG_ISTAT, 0);
        `CHK("istat1", 32'h5, r)
        `CHK("irq", 1'b1, irq)
        apb(1, REG_ISTAT, 32'h5);
        apb(0, REG_ISTAT, 0);
        `CHK("w1c", 32'h0, r)
        $display("test ch1 bypass done");
        low[0] <= 0;
        apb(1, REG_IMASK, 32'h0);
        low[0] <= 1;
        repeat (6) @(posedge clk);
        apb(0, REG_ISTAT, 0);
        `CHK("event", 32'h10, r)
        `CHK("masked", 1'b0, irq)
        apb(1, REG_IMASK, 32'h10);
        repeat (2) @(posedge clk);
        `CHK("unmask", 1'b1, irq)
        apb(1, REG_ISTAT, 32'h10);
        repeat (2) @(posedge clk);
        `CHK("clear", 1'b0, irq)
        $display("test event done");
        apb(1, REG_CFG2, 32'h0a0);
        apb(1, REG_CTRL, 32'h3);
        wait_idle();
        `CHK("circ2", 1'b1, m.regs[DEV_CIRC_ADDR][7])
        `CHK("type2", 1'b1, m.regs[DEV_CMP_ADDR][2])
        `CHK("osc", 1'b0, m.regs[DEV_CLK1_ADDR][4])
        `CHK("mon2", 8'h21, m.regs[DEV_MON2_ADDR] & 8'hb7)
        apb(0, REG_ISTAT, 0);
        `CHK("istat2", 32'h2, r)
        apb(1, REG_CTRL, 32'h6);
        wait_idle();
        `CHK("off2", 1'b0, m.regs[DEV_MON2_ADDR][0])
        $display("test ch2 filter done");
        rst_n <= 0;
        @(posedge clk);
        rst_n <= 1;
        apb(0, REG_CFG2, 0);
        `CHK("cfg2 rst", 32'h40, r)
        apb(0, REG_STATUS, 0);
        `CHK("status rst", 32'h0, r)
        `CHK("irq rst", 1'b0, irq)
        $display("test mid reset done");
        end_sim();
    end
endmodule : voltage_monitor_interrupt_ctl_tb
